//--- hw/nwp_map.vh
// register offsets, field positions and command codes for the network write protect filter
`ifndef NWP_MAP_VH
`define NWP_MAP_VH
// register indexes (byte address is four times the index)
`define NWP_IDX_CTRL 12'h01C0
`define NWP_IDX_LIST 12'h01C1
`define NWP_IDX_LIST_LAST 12'h01E0
`define NWP_IDX_COUNT 12'h01E1
`define NWP_IDX_STATUS 12'h01E2
`define NWP_IDX_LOG 12'h01E3
`define NWP_IDX_LOG_CNT 12'h01E4
// field positions
`define NWP_CTRL_EN_BIT 15
`define NWP_ST_WHOLE_BIT 0
`define NWP_ST_TASK_BIT 1
`define NWP_ST_OVWR_BIT 2
`define NWP_ST_BKUP_BIT 3
`define NWP_ST_UPM_BIT 4
// limits and reset values
`define NWP_MAX_NODES 6'h20
`define NWP_NET_MAX 8'h7F
`define NWP_NODE_MIN 8'h01
`define NWP_NODE_MAX 8'hFE
`define NWP_NODE_ANY 8'hFF
`define NWP_CTRL_RST 16'h0000
`define NWP_COUNT_RST 16'h0000
`define NWP_ENTRY_RST 16'h0000
// write-class command codes
`define NWP_C_MEM_WR 16'h0102
`define NWP_C_MEM_FILL 16'h0103
`define NWP_C_MEM_XFER 16'h0105
`define NWP_C_PAR_WR 16'h0202
`define NWP_C_PAR_FILL 16'h0203
`define NWP_C_PRG_WR 16'h0307
`define NWP_C_PRG_CLR 16'h0308
`define NWP_C_RUN 16'h0401
`define NWP_C_STOP 16'h0402
`define NWP_C_CLK_WR 16'h0702
`define NWP_C_ACC_ACQ 16'h0C01
`define NWP_C_ERR_CLR 16'h2101
`define NWP_C_ELOG_CLR 16'h2103
`define NWP_C_F_WR 16'h2203
`define NWP_C_F_FMT 16'h2204
`define NWP_C_F_DEL 16'h2205
`define NWP_C_F_COPY 16'h2207
`define NWP_C_F_REN 16'h2208
`define NWP_C_F_MXF 16'h220A
`define NWP_C_F_PXF 16'h220B
`define NWP_C_F_GXF 16'h220C
`define NWP_C_DIR 16'h2215
`define NWP_C_FRC 16'h2301
`define NWP_C_FRC_CAN 16'h2302
`endif

//--- hw/nwp_cmd_class.v
// combinational classifier of write-class command codes
`timescale 1ns/1ps
`default_nettype none
`include "nwp_map.vh"
module nwp_cmd_class (
  input wire [15:0] code,
  output reg is_write
);
  // ---------------------------------------------------------
  // code lookup
  // ---------------------------------------------------------
  always @* begin
    case (code)
      `NWP_C_MEM_WR, `NWP_C_MEM_FILL, `NWP_C_MEM_XFER, `NWP_C_PAR_WR, `NWP_C_PAR_FILL,
      `NWP_C_PRG_WR, `NWP_C_PRG_CLR: is_write = 1'b1;
      `NWP_C_RUN, `NWP_C_STOP, `NWP_C_CLK_WR, `NWP_C_ACC_ACQ: is_write = 1'b1;
      `NWP_C_ERR_CLR, `NWP_C_ELOG_CLR, `NWP_C_F_WR, `NWP_C_F_FMT, `NWP_C_F_DEL, `NWP_C_F_COPY,
      `NWP_C_F_REN, `NWP_C_F_MXF, `NWP_C_F_PXF, `NWP_C_F_GXF, `NWP_C_DIR: is_write = 1'b1;
      `NWP_C_FRC, `NWP_C_FRC_CAN: is_write = 1'b1;
      default: is_write = 1'b0; // reads and anything else pass
    endcase
  end
endmodule
`default_nettype wire

//--- hw/nwp_excl_match.v
// exclusion list compare: one comparator per entry
`timescale 1ns/1ps
`default_nettype none
`include "nwp_map.vh"
module nwp_excl_match (
  input wire [511:0] entries,
  input wire [5:0] count,
  input wire [7:0] src_net,
  input wire [7:0] src_node,
  output wire hit
);
  wire [31:0] match; // per-entry match
  // ---------------------------------------------------------
  // per entry compare, only the first count entries are live
  // ---------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_ent
      wire [7:0] e_net; // upper byte is network address
      wire [7:0] e_node; // lower byte is node address
      wire ok;
      assign e_net = entries[i*16+15 -: 8];
      assign e_node = entries[i*16+7 -: 8];
      // ff marks an unspecified node and matches none; out-of-range values are ignored
      assign ok = (e_net <= `NWP_NET_MAX) && (e_node >= `NWP_NODE_MIN) && (e_node <= `NWP_NODE_MAX);
      assign match[i] = ok && (i < count) && (e_net == src_net) && (e_node == src_node);
    end
  endgenerate
  assign hit = |match;
endmodule
`default_nettype wire

//--- hw/nwp_filter.v
// network write protect filter with apb register file
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "nwp_map.vh"
module nwp_filter (
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // incoming command
  input wire cmd_valid,
  input wire [15:0] cmd_code,
  input wire cmd_from_net,
  input wire [7:0] cmd_src_net,
  input wire [7:0] cmd_src_node,
  input wire [7:0] local_net,
  input wire [7:0] local_node,
  // verdict
  output reg cmd_done,
  output reg cmd_exec,
  output reg cmd_error,
  // program memory and file write gates
  input wire dip_pin1,
  input wire whole_read_protect,
  input wire task_read_protect,
  input wire overwrite_prohibit,
  input wire backup_prohibit,
  input wire upm_wr_req,
  input wire upm_wr_task_protected,
  input wire upm_wr_internal,
  input wire file_wr_req,
  input wire file_wr_internal,
  output reg upm_wr_allow,
  output reg file_wr_allow,
  // status flags
  output reg whole_program_read_protect_flag,
  output reg task_read_protect_flag,
  output reg overwrite_prohibit_flag,
  output reg backup_file_prohibit_flag
);
  // ---------------------------------------------------------
  // storage
  // ---------------------------------------------------------
  reg [15:0] network_write_protect_control; // enable in bit 15
  reg [15:0] excluded_node_count; // number of live entries
  reg [15:0] protect_exclusion_list [0:31]; // exclusion entries
  reg [15:0] log_mem [0:15]; // event log of network writes
  reg [3:0] log_ptr; // next log slot
  reg [15:0] log_total; // writes recorded, saturating
  wire [511:0] list_flat; // flattened list for the comparator
  wire [11:0] idx; // word index
  wire excl_hit; // source is in the exclusion list
  wire is_write; // command is write class
  wire protect_en; // network write protection enabled
  wire [5:0] cnt_eff; // clamped count
  wire is_local; // source is the local node
  wire block; // command must be refused
  wire wr_en; // apb write strobe
  wire mapped; // address decodes to a register
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_flat
      assign list_flat[g*16 +: 16] = protect_exclusion_list[g];
    end
  endgenerate
  // ---------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------
  assign idx = paddr[13:2];
  assign mapped = (idx >= `NWP_IDX_CTRL) && (idx <= `NWP_IDX_LOG_CNT);
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  // ---------------------------------------------------------
  // filter decision
  // ---------------------------------------------------------
  assign protect_en = network_write_protect_control[`NWP_CTRL_EN_BIT];
  assign cnt_eff = (excluded_node_count > {10'h000, `NWP_MAX_NODES}) ? `NWP_MAX_NODES :
    excluded_node_count[5:0];
  assign is_local = (cmd_src_net == local_net) && (cmd_src_node == local_node);
  nwp_cmd_class u_class (
    .code(cmd_code),
    .is_write(is_write)
  );
  nwp_excl_match u_match (
    .entries(list_flat),
    .count(cnt_eff),
    .src_net(cmd_src_net),
    .src_node(cmd_src_node),
    .hit(excl_hit)
  );
  // list only consulted behind the enable; serial traffic bypasses
  assign block = protect_en && cmd_from_net && is_write && !is_local && !excl_hit;
  // ---------------------------------------------------------
  // verdict register, one cycle after the command
  // ---------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_done <= 1'b0;
      cmd_exec <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      cmd_done <= cmd_valid;
      cmd_exec <= cmd_valid && !block;
      cmd_error <= cmd_valid && block; // skip and answer error
    end
  end
  // ---------------------------------------------------------
  // registers and event log
  // ---------------------------------------------------------
  integer k;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      network_write_protect_control <= `NWP_CTRL_RST;
      excluded_node_count <= `NWP_COUNT_RST;
      log_ptr <= 4'h0;
      log_total <= 16'h0000;
      for (k = 0; k < 32; k = k + 1) begin
        protect_exclusion_list[k] <= `NWP_ENTRY_RST;
      end
      for (k = 0; k < 16; k = k + 1) begin
        log_mem[k] <= 16'h0000;
      end
    end else begin
      if (wr_en) begin
        if (idx == `NWP_IDX_CTRL) begin
          network_write_protect_control <= pwdata[15:0];
        end else if (idx >= `NWP_IDX_LIST && idx <= `NWP_IDX_LIST_LAST) begin
          protect_exclusion_list[idx[4:0] - 5'h01] <= pwdata[15:0];
        end else if (idx == `NWP_IDX_COUNT) begin
          excluded_node_count <= pwdata[15:0];
        end else if (idx == `NWP_IDX_LOG_CNT) begin
          log_total <= 16'h0000;
        end
      end
      // every network write-class command is logged, pass or block
      if (cmd_valid && cmd_from_net && is_write) begin
        log_mem[log_ptr] <= {cmd_src_net, cmd_src_node};
        log_ptr <= log_ptr + 4'h1;
        if (log_total != 16'hFFFF) begin
          log_total <= log_total + 16'h0001;
        end
      end
    end
  end
  // ---------------------------------------------------------
  // read mux
  // ---------------------------------------------------------
  always @* begin
    prdata = 32'h0000_0000;
    if (idx == `NWP_IDX_CTRL) begin
      prdata = {16'h0000, network_write_protect_control};
    end else if (idx >= `NWP_IDX_LIST && idx <= `NWP_IDX_LIST_LAST) begin
      prdata = {16'h0000, protect_exclusion_list[idx[4:0] - 5'h01]};
    end else if (idx == `NWP_IDX_COUNT) begin
      prdata = {16'h0000, excluded_node_count};
    end else if (idx == `NWP_IDX_STATUS) begin
      prdata = {27'h000_0000, dip_pin1, backup_file_prohibit_flag, overwrite_prohibit_flag,
        task_read_protect_flag, whole_program_read_protect_flag};
    end else if (idx == `NWP_IDX_LOG) begin
      prdata = {16'h0000, log_mem[log_ptr - 4'h1]}; // most recent entry
    end else if (idx == `NWP_IDX_LOG_CNT) begin
      prdata = {16'h0000, log_total};
    end
  end
  // ---------------------------------------------------------
  // program memory and file write gates, status flags
  // ---------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      upm_wr_allow <= 1'b0;
      file_wr_allow <= 1'b0;
      whole_program_read_protect_flag <= 1'b0;
      task_read_protect_flag <= 1'b0;
      overwrite_prohibit_flag <= 1'b0;
      backup_file_prohibit_flag <= 1'b0;
    end else begin
      whole_program_read_protect_flag <= whole_read_protect;
      task_read_protect_flag <= task_read_protect;
      overwrite_prohibit_flag <= overwrite_prohibit;
      backup_file_prohibit_flag <= backup_prohibit;
      // dip pin blocks all program memory writes; option guards protected tasks only when read protect on
      upm_wr_allow <= upm_wr_req && !dip_pin1 &&
        !(overwrite_prohibit && upm_wr_task_protected &&
        (whole_read_protect || task_read_protect)) &&
        (upm_wr_internal || !(protect_en && cmd_from_net));
      // startup transfer, backup and data_file_write_instruction bypass
      file_wr_allow <= file_wr_req && (file_wr_internal || !block);
    end
  end
endmodule
`default_nettype wire

//--- test/nwp_chk.sv
// assertion checker bound to the network write protect filter
`timescale 1ns/1ps
`default_nettype none
module nwp_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_from_net,
  input wire logic cmd_done,
  input wire logic cmd_exec,
  input wire logic cmd_error,
  input wire logic dip_pin1,
  input wire logic whole_read_protect,
  input wire logic task_read_protect,
  input wire logic backup_prohibit,
  input wire logic upm_wr_req,
  input wire logic upm_wr_internal,
  input wire logic upm_wr_allow,
  input wire logic file_wr_req,
  input wire logic file_wr_internal,
  input wire logic file_wr_allow,
  input wire logic whole_program_read_protect_flag,
  input wire logic task_read_protect_flag,
  input wire logic backup_file_prohibit_flag
);
  // ------------------------------------------------------------
  // verdict and gate relations
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  verdict_once_a: assert property (cmd_valid |=> cmd_done && (cmd_exec ^ cmd_error))
    else $error("command without single verdict");
  serial_pass_a: assert property (cmd_valid && !cmd_from_net |=> cmd_exec)
    else $error("serial command refused");
  dip_gate_a: assert property (dip_pin1 |=> !upm_wr_allow)
    else $error("program write allowed under dip");
  open_write_a: assert property (upm_wr_req && upm_wr_internal && !dip_pin1 && !whole_read_protect
    && !task_read_protect |=> upm_wr_allow)
    else $error("unprotected program write refused");
  file_bypass_a: assert property (file_wr_req && file_wr_internal |=> file_wr_allow)
    else $error("internal file write refused");
  whole_flag_a: assert property ($rose(whole_read_protect) |=> whole_program_read_protect_flag)
    else $error("whole read flag missed");
  task_flag_a: assert property (task_read_protect ##1 task_read_protect |-> task_read_protect_flag)
    else $error("task read flag missed");
  bkup_flag_a: assert property (!backup_prohibit |=> !backup_file_prohibit_flag)
    else $error("backup flag stuck");
  // main scenarios reached
  cover property (cmd_valid && cmd_from_net ##1 cmd_error);
  cover property (cmd_valid && cmd_from_net ##1 cmd_exec);
  cover property (upm_wr_req ##1 !upm_wr_allow);
endmodule
bind nwp_filter nwp_chk u_chk (.clk, .rst, .cmd_valid, .cmd_from_net, .cmd_done, .cmd_exec, .cmd_error,
  .dip_pin1, .whole_read_protect, .task_read_protect, .backup_prohibit, .upm_wr_req, .upm_wr_internal,
  .upm_wr_allow, .file_wr_req, .file_wr_internal, .file_wr_allow, .whole_program_read_protect_flag,
  .task_read_protect_flag, .backup_file_prohibit_flag);
`default_nettype wire

//--- test/nwp_host.sv
// remote station model that sends protocol commands to the filter
`timescale 1ns/1ps
`default_nettype none
module nwp_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic [15:0] cmd_code,
  output logic cmd_from_net,
  output logic [7:0] cmd_src_net,
  output logic [7:0] cmd_src_node
);
  // idle station at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 16'h0000;
    cmd_from_net = 1'b1;
    {cmd_src_net, cmd_src_node} = 16'h0000;
  end
  // one command for one cycle, then code and source address go stale (inverted)
  task automatic send(input logic [15:0] c, input logic n, input logic [15:0] a);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_from_net <= n;
    {cmd_src_net, cmd_src_node} <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    {cmd_src_net, cmd_src_node} <= ~a;
    #1;
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the network write protect filter
`timescale 1ns/1ps
`default_nettype none
`include "nwp_map.vh"
module tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, cmd_valid, cmd_from_net, cmd_done, cmd_exec, cmd_error;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cmd_code;
  logic [7:0] src_net, src_node;
  logic dip, whole, task_rp, ovwr, bkup, upm_req, upm_tp, file_req, file_int;
  logic upm_allow, file_allow, f_whole, f_task, f_ovwr, f_bkup;
  int fail_count, checks_done;
  // write-class command codes that protection must refuse
  logic [15:0] wr_codes [24] = '{16'h0102, 16'h0103, 16'h0105, 16'h0202, 16'h0203, 16'h0307, 16'h0308,
    16'h0401, 16'h0402, 16'h0702, 16'h0C01, 16'h2101, 16'h2103, 16'h2203, 16'h2204, 16'h2205, 16'h2207,
    16'h2208, 16'h220A, 16'h220B, 16'h220C, 16'h2215, 16'h2301, 16'h2302};
  nwp_filter u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .cmd_valid, .cmd_code, .cmd_from_net, .cmd_src_net(src_net), .cmd_src_node(src_node), .local_net(8'h01),
    .local_node(8'h0A), .cmd_done, .cmd_exec, .cmd_error, .dip_pin1(dip), .whole_read_protect(whole),
    .task_read_protect(task_rp), .overwrite_prohibit(ovwr), .backup_prohibit(bkup), .upm_wr_req(upm_req),
    .upm_wr_task_protected(upm_tp), .upm_wr_internal(1'b1), .file_wr_req(file_req), .file_wr_internal(file_int),
    .upm_wr_allow(upm_allow), .file_wr_allow(file_allow), .whole_program_read_protect_flag(f_whole),
    .task_read_protect_flag(f_task), .overwrite_prohibit_flag(f_ovwr), .backup_file_prohibit_flag(f_bkup));
  nwp_host u_host (.clk, .cmd_valid, .cmd_code, .cmd_from_net, .cmd_src_net(src_net), .cmd_src_node(src_node));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // apb transfer; read data and error taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d, e, input logic er);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, d};
    @(posedge clk);
    penable <= 1'b1;
    // access phase: sample at each rising edge until pready is seen high
    while (!got && n < 20) begin
      @(posedge clk);
      {got, rd, err} = {pready, prdata, pslverr};
      n++;
    end
    {psel, penable} <= 2'b00;
    if (got !== 1'b1) begin
      fail_count++;
      conclude();
    end
    if (!w) check("rdata", rd, e);
    check("pslverr", err, er);
  endtask
  // one command from the remote station and its verdict
  task automatic cmd(input logic [15:0] c, input logic n, input logic [15:0] a, input logic ex);
    u_host.send(c, n, a);
    check("verdict", {cmd_done, cmd_exec, cmd_error}, {1'b1, ex, !ex});
  endtask
  // level inputs for the program gate, checked two edges later
  task automatic gate(input logic [8:0] v, input logic [5:0] e);
    @(posedge clk);
    {dip, whole, task_rp, ovwr, bkup, upm_req, upm_tp, file_req, file_int} <= v;
    repeat (2) @(posedge clk);
    #1;
    check("gates", {f_bkup, f_ovwr, f_task, f_whole, upm_allow, file_allow}, e);
  endtask
  // ------------------------------------------------------------
  // clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #2_000_000;
    fail_count++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {dip, whole, task_rp, ovwr, bkup, upm_req, upm_tp, file_req, file_int} = '0;
    fail_count = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(0, `NWP_IDX_CTRL, 0, 0, 0);
    apb(0, `NWP_IDX_COUNT, 0, 0, 0);
    apb(0, 12'h0100, 0, 0, 1);
    cmd(16'h0102, 1, 16'h0203, 1);
    apb(1, `NWP_IDX_CTRL, 32'h0000_8000, 0, 0);
    apb(0, `NWP_IDX_CTRL, 0, 32'h0000_8000, 0);
    foreach (wr_codes[i]) cmd(wr_codes[i], 1, 16'h0203, 0);
    cmd(16'h0101, 1, 16'h0203, 1);
    cmd(16'h0102, 0, 16'h0203, 1);
    cmd(16'h0102, 1, 16'h010A, 1);
    apb(1, `NWP_IDX_LIST, 32'h0000_1234, 0, 0);
    apb(1, `NWP_IDX_LIST + 12'h001, 32'h0000_12FF, 0, 0);
    cmd(16'h0102, 1, 16'h1234, 0);
    apb(1, `NWP_IDX_COUNT, 32'h0000_0002, 0, 0);
    cmd(16'h0102, 1, 16'h1234, 1);
    cmd(16'h0102, 1, 16'h1235, 0);
    cmd(16'h0102, 1, 16'h12FE, 0);
    apb(1, `NWP_IDX_LIST_LAST, 32'h0000_7F01, 0, 0);
    apb(1, `NWP_IDX_COUNT, 32'h0000_0020, 0, 0);
    cmd(16'h0102, 1, 16'h7F01, 1);
    apb(1, `NWP_IDX_LOG_CNT, 0, 0, 0);
    cmd(16'h2301, 1, 16'h0456, 0);
    apb(0, `NWP_IDX_LOG_CNT, 0, 32'h0000_0001, 0);
    apb(0, `NWP_IDX_LOG, 0, 32'h0000_0456, 0);
    apb(1, `NWP_IDX_CTRL, 0, 0, 0);
    cmd(16'h2301, 1, 16'h0456, 1);
    gate(9'b1_1011_1111, 6'b110101);
    apb(0, `NWP_IDX_STATUS, 0, 32'h0000_001D, 0);
    gate(9'b0_1011_1111, 6'b110101);
    gate(9'b0_1011_1011, 6'b110111);
    gate(9'b0_0011_1111, 6'b110011);
    gate(9'b0_0101_1111, 6'b101011);
    conclude();
  end
endmodule
`default_nettype wire
